/* src/phy_page1_consts.svh */
// Constants for the extended page 1 control register bank
// What this block does
// - Registers 16-30 show page 1 when page select holds 0x0001; zero restores main.
// - Bits 13 and 12 put the second and first indicator outputs into serial mode.
// - Bit 11 set blinks LEDs on low-power hold release; clear suppresses it.
// - Fast-link-failure pin is driven only while bit 4 is set; defaults to one.
// - Crossover field: 00 automatic, 10 forced MDI, 11 forced MDI-X, 01 reserved.
// - Read-only media field: 00 none, 01 copper, 10 and 11 reserved.
// - Bit 5 lets 10BASE-T assert receive data valid without a preamble.
// - Bits 15:11 of inline-power register show the five-bit management address.
// - Inline-power search runs only while bit 10 is set; status valid only then.
// - Detection status 9:8: 00 searching, 01 needs power, 10 no power needed.
// - Eight-bit copper CRC error count in bits 7:0, cleared when the register is read.
`ifndef PHY_PAGE1_CONSTS_SVH
`define PHY_PAGE1_CONSTS_SVH

`define PAGE_SELECT_ADDR   5'h1F
`define PAGE_MAIN          16'h0000
`define PAGE_EXT1          16'h0001
`define EXT_MODE_ADDR      5'h13
`define SLEEP_TIMER_ADDR   5'h14
`define INLINE_POWER_ADDR  5'h17

`define EXT_MODE_RESET     16'h0010
`define EXT_MODE_WMASK     16'h381C
`define SLEEP_TIMER_RESET  16'h2000
`define SLEEP_TIMER_WMASK  16'h7C20
`define INLINE_POWER_RESET 16'h0000
`define INLINE_POWER_WMASK 16'h0400

`define SERIAL_SECOND_BIT  13
`define SERIAL_FIRST_BIT   12
`define BLINK_ENABLE_BIT   11
`define FAST_FAIL_BIT      4
`define XOVER_HI           3
`define XOVER_LO           2
`define SLEEP_HI           14
`define SLEEP_LO           13
`define WAKE_HI            12
`define WAKE_LO            11
`define SLOW_CLOCK_BIT     10
`define MEDIA_HI           7
`define MEDIA_LO           6
`define NO_PREAMBLE_BIT    5
`define ADDR_HI            15
`define ADDR_LO            11
`define DETECT_ENABLE_BIT  10
`define DETECT_HI          9
`define DETECT_LO          8
`define CRC_HI             7
`define CRC_LO             0

`define SLEEP_STEP         3'h1
`define WAKE_MS_CODE0      11'h0A0
`define WAKE_MS_CODE1      11'h190
`define WAKE_MS_CODE2      11'h320
`define WAKE_MS_CODE3      11'h7D0
`define CRC_MAX            8'hFF
`define CRC_ONE            8'h01

`endif

/* src/phy_page1_pkg.sv */
// Types shared by the extended page 1 register bank
package phy_page1_pkg;
  typedef enum logic [1:0] {
    XOVER_AUTO,
    XOVER_MDI,
    XOVER_MDIX
  } crossover_type;
  typedef logic [15:0] reg_word_type;
endpackage

/* src/crc_count_if.sv */
// Carrier between the register bank and its CRC error counter
`timescale 1ns/100ps
`default_nettype none
interface crc_count_if;
  logic       error_pulse;
  logic       clear;
  logic [7:0] count;
  modport counter (input error_pulse, input clear, output count);
  modport owner   (output error_pulse, output clear, input count);
endinterface
`default_nettype wire

/* src/crc_error_counter.sv */
// Eight-bit copper CRC error counter, cleared on read
`timescale 1ns/100ps
`default_nettype none
`include "phy_page1_consts.svh"
module crc_error_counter (
  input wire logic     clk,
  input wire logic     rst_n,
  crc_count_if.counter bus
);
  logic [7:0] count;
  logic [7:0] next_count;

  // An error landing in the clearing cycle is kept as the first new count
  always_comb begin
    next_count = count;
    if (bus.clear) begin
      next_count = bus.error_pulse ? `CRC_ONE : 8'h00;
    end else if (bus.error_pulse && count != `CRC_MAX) begin
      // Saturates so a long burst never wraps to a small figure
      next_count = count + `CRC_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 8'h00;
    end else begin
      count <= next_count;
    end
  end

  assign bus.count = count;
endmodule
`default_nettype wire

/* src/phy_page1_regs.sv */
// Extended page 1 control and status register bank with page select
`timescale 1ns/100ps
`default_nettype none
`include "phy_page1_consts.svh"
module phy_page1_regs (
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic                        soft_reset,
  input  wire logic [4:0]                  mgmt_addr,
  input  wire logic                        mgmt_write,
  input  wire logic                        mgmt_read,
  input  wire logic [15:0]                 mgmt_wdata,
  output logic [15:0]                      mgmt_rdata,
  output logic                             mgmt_rvalid,
  input  wire logic [4:0]                  phy_address_pin,
  input  wire logic                        low_power_hold_pin,
  input  wire logic                        crc_error,
  input  wire logic [1:0]                  media_selected,
  input  wire logic [1:0]                  pd_status,
  input  wire logic                        fast_link_fail_in,
  output logic                             indicator_out_first_serial,
  output logic                             indicator_out_second_serial,
  output logic                             led_blink_start,
  output logic                             fast_link_fail_out,
  output logic                             fast_link_fail_oe_n,
  output phy_page1_pkg::crossover_type     crossover_mode,
  output logic [2:0]                       sleep_delay_s,
  output logic [10:0]                      wakeup_time_ms,
  output logic                             slow_mdc_hint,
  output logic                             rx_no_preamble_enable,
  output logic                             pd_detect_enable
);
  logic                      rst_sync1;
  logic                      rst_n;
  logic [4:0]                addr_sync1;
  logic [4:0]                addr_sync2;
  logic                      hold_sync1;
  logic                      hold_sync2;
  logic                      hold_prev;
  phy_page1_pkg::reg_word_type page_select;
  phy_page1_pkg::reg_word_type ext_mode;
  phy_page1_pkg::reg_word_type sleep_timer;
  phy_page1_pkg::reg_word_type inline_power;
  phy_page1_pkg::reg_word_type next_page_select;
  phy_page1_pkg::reg_word_type next_ext_mode;
  phy_page1_pkg::reg_word_type next_sleep_timer;
  phy_page1_pkg::reg_word_type next_inline_power;
  logic [15:0]               next_rdata;
  logic                      next_blink;
  logic                      next_flf;
  logic                      page1;
  logic                      page1_wr;
  crc_count_if               crc ();

  // Reset is released through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync1 <= 1'b0;
      rst_n     <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_n     <= rst_sync1;
    end
  end

  // Address and low-power hold pins pass two flops before any logic looks at them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_sync1 <= 5'h00;
      addr_sync2 <= 5'h00;
      hold_sync1 <= 1'b0;
      hold_sync2 <= 1'b0;
      hold_prev  <= 1'b0;
    end else begin
      addr_sync1 <= phy_address_pin;
      addr_sync2 <= addr_sync1;
      hold_sync1 <= low_power_hold_pin;
      hold_sync2 <= hold_sync1;
      hold_prev  <= hold_sync2;
    end
  end

  assign page1    = (page_select == `PAGE_EXT1);
  assign page1_wr = mgmt_write && page1;

  always_comb begin
    next_page_select  = page_select;
    next_ext_mode     = ext_mode;
    next_sleep_timer  = sleep_timer;
    next_inline_power = inline_power;
    if (mgmt_write && mgmt_addr == `PAGE_SELECT_ADDR) begin
      next_page_select = mgmt_wdata;
    end
    // Only writable bits take the written value; reserved bits stay zero
    if (page1_wr && mgmt_addr == `EXT_MODE_ADDR) begin
      next_ext_mode = mgmt_wdata & `EXT_MODE_WMASK;
    end
    if (page1_wr && mgmt_addr == `SLEEP_TIMER_ADDR) begin
      next_sleep_timer = mgmt_wdata & `SLEEP_TIMER_WMASK;
    end
    if (page1_wr && mgmt_addr == `INLINE_POWER_ADDR) begin
      next_inline_power = mgmt_wdata & `INLINE_POWER_WMASK;
    end
    // Software reset drops the page back to main but keeps sticky fields
    if (soft_reset) begin
      next_page_select = `PAGE_MAIN;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page_select  <= `PAGE_MAIN;
      ext_mode     <= `EXT_MODE_RESET;
      sleep_timer  <= `SLEEP_TIMER_RESET;
      inline_power <= `INLINE_POWER_RESET;
    end else begin
      page_select  <= next_page_select;
      ext_mode     <= next_ext_mode;
      sleep_timer  <= next_sleep_timer;
      inline_power <= next_inline_power;
    end
  end

  // Read path; status fields are assembled at read time
  always_comb begin
    next_rdata = 16'h0000;
    if (mgmt_read) begin
      if (mgmt_addr == `PAGE_SELECT_ADDR) begin
        next_rdata = page_select;
      end else if (page1) begin
        unique case (mgmt_addr)
          `EXT_MODE_ADDR: begin
            next_rdata = ext_mode;
          end
          `SLEEP_TIMER_ADDR: begin
            next_rdata = sleep_timer;
            next_rdata[`MEDIA_HI:`MEDIA_LO] = media_selected;
          end
          `INLINE_POWER_ADDR: begin
            next_rdata = inline_power;
            next_rdata[`ADDR_HI:`ADDR_LO] = addr_sync2;
            // Status is meaningless with detection off, so it reads as searching
            next_rdata[`DETECT_HI:`DETECT_LO] =
              inline_power[`DETECT_ENABLE_BIT] ? pd_status : 2'h0;
            next_rdata[`CRC_HI:`CRC_LO] = crc.count;
          end
          default: begin
            next_rdata = 16'h0000;
          end
        endcase
      end
    end
  end

  assign crc.error_pulse = crc_error;
  assign crc.clear = soft_reset ||
    (mgmt_read && page1 && mgmt_addr == `INLINE_POWER_ADDR);

  crc_error_counter counter (
    .clk   (clk),
    .rst_n (rst_n),
    .bus   (crc)
  );

  assign next_blink = hold_prev && !hold_sync2 && ext_mode[`BLINK_ENABLE_BIT];
  assign next_flf   = fast_link_fail_in && ext_mode[`FAST_FAIL_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_rdata         <= 16'h0000;
      mgmt_rvalid        <= 1'b0;
      led_blink_start    <= 1'b0;
      fast_link_fail_out <= 1'b0;
    end else begin
      mgmt_rdata         <= next_rdata;
      mgmt_rvalid        <= mgmt_read;
      led_blink_start    <= next_blink;
      fast_link_fail_out <= next_flf;
    end
  end

  assign indicator_out_second_serial = ext_mode[`SERIAL_SECOND_BIT];
  assign indicator_out_first_serial  = ext_mode[`SERIAL_FIRST_BIT];
  assign fast_link_fail_oe_n   = !ext_mode[`FAST_FAIL_BIT];
  assign slow_mdc_hint         = sleep_timer[`SLOW_CLOCK_BIT];
  assign rx_no_preamble_enable = sleep_timer[`NO_PREAMBLE_BIT];
  assign pd_detect_enable      = inline_power[`DETECT_ENABLE_BIT];
  assign sleep_delay_s = {1'b0, sleep_timer[`SLEEP_HI:`SLEEP_LO]} + `SLEEP_STEP;

  always_comb begin
    // Reserved code 01 falls back to automatic crossover
    unique case (ext_mode[`XOVER_HI:`XOVER_LO])
      2'h0: crossover_mode = phy_page1_pkg::XOVER_AUTO;
      2'h1: crossover_mode = phy_page1_pkg::XOVER_AUTO;
      2'h2: crossover_mode = phy_page1_pkg::XOVER_MDI;
      2'h3: crossover_mode = phy_page1_pkg::XOVER_MDIX;
    endcase
    unique case (sleep_timer[`WAKE_HI:`WAKE_LO])
      2'h0: wakeup_time_ms = `WAKE_MS_CODE0;
      2'h1: wakeup_time_ms = `WAKE_MS_CODE1;
      2'h2: wakeup_time_ms = `WAKE_MS_CODE2;
      2'h3: wakeup_time_ms = `WAKE_MS_CODE3;
    endcase
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_page1_write(logic [4:0] a);
    mgmt_write && page1 && mgmt_addr == a;
  endsequence
  sequence s_page1_read(logic [4:0] a);
    mgmt_read && page1 && mgmt_addr == a;
  endsequence

  property p_page_gate;
    mgmt_read && !page1 && mgmt_addr != `PAGE_SELECT_ADDR |=> mgmt_rdata == 16'h0000;
  endproperty
  a_page_gate: assert property (p_page_gate) else $error("page gate leak");

  property p_serial_led;
    s_page1_write(`EXT_MODE_ADDR) |=>
      indicator_out_second_serial == $past(mgmt_wdata[`SERIAL_SECOND_BIT]) &&
      indicator_out_first_serial == $past(mgmt_wdata[`SERIAL_FIRST_BIT]);
  endproperty
  a_serial_led: assert property (p_serial_led) else $error("serial mode bit lost");

  property p_blink;
    // The pulse reflects the enable bit as it stood one cycle earlier
    led_blink_start |-> $past(ext_mode[`BLINK_ENABLE_BIT]) && $past(hold_prev) && !hold_prev;
  endproperty
  a_blink: assert property (p_blink) else $error("unexpected blink");

  property p_flf;
    // Enable follows the bit at once; the registered pin lags one cycle
    !ext_mode[`FAST_FAIL_BIT] |-> fast_link_fail_oe_n ##1 !fast_link_fail_out;
  endproperty
  a_flf: assert property (p_flf) else $error("fast fail pin driven");

  property p_xover;
    ext_mode[`XOVER_HI:`XOVER_LO] == 2'h3 |-> crossover_mode == phy_page1_pkg::XOVER_MDIX;
  endproperty
  a_xover: assert property (p_xover) else $error("crossover decode");

  property p_sleep;
    s_page1_write(`SLEEP_TIMER_ADDR) ##0 mgmt_wdata[`SLEEP_HI:`SLEEP_LO] == 2'h3 |=>
      sleep_delay_s == 3'h4;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep delay decode");

  property p_wake;
    s_page1_write(`SLEEP_TIMER_ADDR) ##0 mgmt_wdata[`WAKE_HI:`WAKE_LO] == 2'h3 |=>
      wakeup_time_ms == `WAKE_MS_CODE3;
  endproperty
  a_wake: assert property (p_wake) else $error("wake time decode");

  property p_crc_clear;
    s_page1_read(`INLINE_POWER_ADDR) ##0 !crc_error ##1 !crc_error |-> crc.count == 8'h00;
  endproperty
  a_crc_clear: assert property (p_crc_clear) else $error("crc count not cleared");

  property p_reserved;
    s_page1_read(`EXT_MODE_ADDR) |=> (mgmt_rdata & ~`EXT_MODE_WMASK) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_soft;
    soft_reset && !mgmt_write |=> ext_mode == $past(ext_mode) && sleep_timer == $past(sleep_timer);
  endproperty
  a_soft: assert property (p_soft) else $error("sticky field lost");

  property p_pd_valid;
    s_page1_read(`INLINE_POWER_ADDR) ##0 !pd_detect_enable |=>
      mgmt_rdata[`DETECT_HI:`DETECT_LO] == 2'h0;
  endproperty
  a_pd_valid: assert property (p_pd_valid) else $error("status shown while off");
endmodule
`default_nettype wire

/* verif/mgmt_station.sv */
// Station management controller model driving the register strobes
`timescale 1ns/100ps
`default_nettype none
module mgmt_station (
  input  wire logic        clk,
  output logic [4:0]       mgmt_addr,
  output logic             mgmt_write,
  output logic             mgmt_read,
  output logic [15:0]      mgmt_wdata,
  input  wire logic [15:0] mgmt_rdata,
  input  wire logic        mgmt_rvalid
);
  initial begin
    mgmt_addr = 5'h00;
    mgmt_write = 1'b0;
    mgmt_read = 1'b0;
    mgmt_wdata = 16'h0000;
  end
  // Idle lines carry the inverse so a stale value can never pass as fresh
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_write = 1'b1;
    @(negedge clk);
    mgmt_write = 1'b0;
    mgmt_addr = ~a;
    mgmt_wdata = ~d;
  endtask
  // Answer must come exactly one cycle after the read is taken
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk);
    mgmt_addr = a;
    mgmt_read = 1'b1;
    @(negedge clk);
    mgmt_read = 1'b0;
    mgmt_addr = ~a;
    d = (mgmt_rvalid === 1'b1) ? mgmt_rdata : 16'hXXXX;
  endtask
  task automatic page(input logic [15:0] p);
    wr(5'h1F, p);
  endtask
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the extended page 1 register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
  logic clk, reset_n, soft_reset, crc_error, low_power_hold_pin, fast_link_fail_in;
  logic mgmt_write, mgmt_read, mgmt_rvalid, led_blink_start, slow_mdc_hint;
  logic indicator_out_first_serial, indicator_out_second_serial, pd_detect_enable;
  logic fast_link_fail_out, fast_link_fail_oe_n, rx_no_preamble_enable;
  logic [4:0]  mgmt_addr, phy_address_pin;
  logic [15:0] mgmt_wdata, mgmt_rdata, pg, m13, m14, m17;
  logic [1:0]  media_selected, pd_status;
  logic [2:0]  sleep_delay_s;
  logic [10:0] wakeup_time_ms;
  logic [3:0]  blinks;
  phy_page1_pkg::crossover_type crossover_mode;
  int num_errors = 0, samples_checked = 0, crc;
  logic [10:0] wake_ms [4] = '{11'h0A0, 11'h190, 11'h320, 11'h7D0};
  logic [4:0]  addr_pick [3] = '{5'h13, 5'h14, 5'h17};

  phy_page1_regs dut_u (.clk, .reset_n, .soft_reset, .mgmt_addr, .mgmt_write, .mgmt_read,
    .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid, .phy_address_pin, .low_power_hold_pin,
    .crc_error, .media_selected, .pd_status, .fast_link_fail_in,
    .indicator_out_first_serial, .indicator_out_second_serial, .led_blink_start,
    .fast_link_fail_out, .fast_link_fail_oe_n, .crossover_mode, .sleep_delay_s,
    .wakeup_time_ms, .slow_mdc_hint, .rx_no_preamble_enable, .pd_detect_enable);
  mgmt_station station_u (.clk, .mgmt_addr, .mgmt_write, .mgmt_read, .mgmt_wdata,
    .mgmt_rdata, .mgmt_rvalid);

  function automatic logic [15:0] expect_rd(input logic [4:0] a);
    if (a == 5'h1F) return pg;
    if (pg != 16'h0001) return 16'h0000;
    case (a)
      5'h13: return m13 & 16'h381C;
      5'h14: return (m14 & 16'h7C20) | {8'h00, media_selected, 6'h00};
      5'h17: return {phy_address_pin, m17[10], m17[10] ? pd_status : 2'b00, 8'(crc)};
      default: return 16'h0000;
    endcase
  endfunction
  function automatic phy_page1_pkg::crossover_type xover_expect(input logic [1:0] c);
    if (c == 2'b10) return phy_page1_pkg::XOVER_MDI;
    if (c == 2'b11) return phy_page1_pkg::XOVER_MDIX;
    return phy_page1_pkg::XOVER_AUTO;
  endfunction
  task automatic w(input logic [4:0] a, input logic [15:0] d);
    station_u.wr(a, d);
    if (a == 5'h1F) pg = d;
    else if (pg == 16'h0001 && a == 5'h13) m13 = d;
    else if (pg == 16'h0001 && a == 5'h14) m14 = d;
    else if (pg == 16'h0001 && a == 5'h17) m17 = d;
  endtask
  task automatic r(input logic [4:0] a);
    logic [15:0] e, d;
    e = expect_rd(a);
    station_u.rd(a, d);
    `CHK(d, e)
    if (a == 5'h17 && pg == 16'h0001) crc = 0;
  endtask
  task automatic chk_out;
    `CHK(indicator_out_second_serial, m13[13])
    `CHK(indicator_out_first_serial, m13[12])
    `CHK(fast_link_fail_oe_n, ~m13[4])
    `CHK(crossover_mode, xover_expect(m13[3:2]))
    `CHK(sleep_delay_s, 3'(m14[14:13]) + 3'h1)
    `CHK(wakeup_time_ms, wake_ms[m14[12:11]])
    `CHK(slow_mdc_hint, m14[10])
    `CHK(rx_no_preamble_enable, m14[5])
    `CHK(pd_detect_enable, m17[10])
  endtask
  task automatic errs(input int n);
    repeat (n) begin
      @(negedge clk);
      crc_error = 1'b1;
    end
    @(negedge clk);
    crc_error = 1'b0;
    crc = (crc + n > 255) ? 255 : crc + n;
  endtask
  task automatic hold_release;
    @(negedge clk);
    low_power_hold_pin = 1'b1;
    repeat (6) @(negedge clk);
    low_power_hold_pin = 1'b0;
    blinks = 4'h0;
    repeat (8) begin
      @(negedge clk);
      blinks = blinks + 4'(led_blink_start);
    end
    `CHK(blinks, {3'b000, m13[11]})
  endtask
  task automatic hw_reset;
    reset_n = 1'b0;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    pg = 16'h0000;
    m13 = 16'h0010;
    m14 = 16'h2000;
    m17 = 16'h0000;
    crc = 0;
  endtask
  task automatic close_out;
    $display("Mismatches %0d, comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Whole run is under a thousand cycles; the limit of 20000 cycles leaves wide margin
  initial begin
    #400000;
    num_errors++;
    close_out;
  end
  initial begin
    {soft_reset, crc_error, low_power_hold_pin, fast_link_fail_in} = 4'h0;
    phy_address_pin = 5'h05;
    media_selected = 2'b01;
    pd_status = 2'b01;
    void'($urandom(32'h7858));
    hw_reset;
    r(5'h1F);
    w(5'h13, 16'hFFFF);
    r(5'h13);
    chk_out;
    station_u.page(16'h0001);
    pg = 16'h0001;
    r(5'h13);
    r(5'h14);
    r(5'h17);
    for (int i = 0; i < 4; i++) begin
      w(5'h13, {14'h0000, 2'(i)} << 2);
      w(5'h14, {1'b0, 2'(i), 2'(i), 11'h000});
      chk_out;
    end
    repeat (30) begin
      phy_address_pin = 5'($urandom);
      media_selected = 2'($urandom_range(1, 0));
      pd_status = 2'($urandom_range(2, 0));
      w(addr_pick[$urandom_range(2, 0)], 16'($urandom));
      r(5'h13);
      r(5'h14);
      r(5'h17);
      chk_out;
    end
    w(5'h13, 16'h0800);
    hold_release;
    w(5'h13, 16'h0000);
    hold_release;
    fast_link_fail_in = 1'b1;
    w(5'h13, 16'h0010);
    repeat (2) @(negedge clk);
    `CHK(fast_link_fail_out, 1'b1)
    w(5'h13, 16'h0000);
    repeat (2) @(negedge clk);
    `CHK(fast_link_fail_out, 1'b0)
    chk_out;
    errs($urandom_range(9, 1));
    r(5'h17);
    r(5'h17);
    errs(300);
    r(5'h17);
    w(5'h13, 16'h3A1C);
    w(5'h14, 16'h5C20);
    errs(3);
    @(negedge clk);
    soft_reset = 1'b1;
    @(negedge clk);
    soft_reset = 1'b0;
    pg = 16'h0000;
    crc = 0;
    r(5'h1F);
    chk_out;
    w(5'h1F, 16'h0002);
    w(5'h13, 16'hFFFF);
    r(5'h13);
    w(5'h1F, 16'h0001);
    r(5'h13);
    r(5'h14);
    r(5'h17);
    r(5'h10);
    hw_reset;
    w(5'h1F, 16'h0001);
    r(5'h13);
    r(5'h14);
    chk_out;
    close_out;
  end
endmodule
`default_nettype wire
